// >>> hw/cif_map.vh
// Register offsets, field positions, reset values and limits of the CAN filter block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CIF_MAP_VH
`define CIF_MAP_VH

// Byte offsets on the AXI4-Lite register bus
`define CIF_OFF_MODULE_CTRL0   8'h00
`define CIF_OFF_MODULE_CTRL1   8'h04
`define CIF_OFF_BIT_TIMING0    8'h08
`define CIF_OFF_BIT_TIMING1    8'h0c
`define CIF_OFF_RX_FLAG_REG    8'h10
`define CIF_OFF_RX_IRQ_EN      8'h14
`define CIF_OFF_TX_FLAG_REG    8'h18
`define CIF_OFF_TX_CTRL_REG    8'h1c
`define CIF_OFF_ACCEPT_CTRL    8'h20
`define CIF_OFF_ERR_COUNTERS   8'h24
`define CIF_OFF_MODE_STATUS    8'h28
`define CIF_OFF_PATTERN_BASE   8'h40
`define CIF_OFF_DONTCARE_BASE  8'h60

// module_ctrl0 fields
`define CIF_MC0_SOFT_RESET     0
`define CIF_MC0_SLEEP_ACK      1
`define CIF_MC0_STOP_IN_WAIT   2
`define CIF_MC0_RESET          8'h01

// rx_flag_reg fields (flags), rx_irq_en uses the same positions
`define CIF_RF_RX_FULL         0
`define CIF_RF_OVERRUN         1
`define CIF_RF_BUSOFF          2
`define CIF_RF_TX_PASSIVE      3
`define CIF_RF_RX_PASSIVE      4
`define CIF_RF_TX_WARN         5
`define CIF_RF_RX_WARN         6
`define CIF_RF_WAKE            7

// Acceptance filter modes
`define CIF_AM_WIDE            2'h0
`define CIF_AM_HALF            2'h1
`define CIF_AM_BYTE            2'h2
`define CIF_AM_CLOSED          2'h3

// Error counter limits
`define CIF_WARN_LIMIT         9'h060
`define CIF_PASSIVE_LIMIT      9'h07f
`define CIF_BUSOFF_LIMIT       9'h0ff

// AXI responses
`define CIF_RESP_OKAY          2'h0
`define CIF_RESP_SLVERR        2'h2

`endif

// >>> hw/cif_accept_mem.v
// Acceptance pattern and don't-care memory: 16 bytes, registered read.
// Assumes one clock; writes are already qualified by the caller.
`timescale 1ns/10ps
`default_nettype none
module cif_accept_mem (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write port
  input  wire        wr_en,
  input  wire [3:0]  wr_addr,
  input  wire [7:0]  wr_data,
  // Registered read port
  input  wire [3:0]  rd_addr,
  output reg  [7:0]  rd_data,
  // Whole contents for the comparators
  output wire [127:0] flat
);
  reg [7:0] mem_q [0:15];
  integer   i;

  // Bytes 0..7 pattern, 8..15 don't-care; cleared on reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 16; i = i + 1)
        mem_q[i] <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      if (wr_en)
        mem_q[wr_addr] <= wr_data;
      rd_data <= mem_q[rd_addr];
    end
  end

  // Flat view feeds the parallel comparators
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gflat
      assign flat[g*8 +: 8] = mem_q[g];
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hw/cif_top.v
// CAN identifier filter, interrupt flags, protection and mode selection.
// Assumes a protocol engine that supplies frame strobes and error counters.
//
// Contract
// - Received identifier bits compared with pattern, skipping don't-care bits.
// - Accepted message sets receive-full and loads three-bit hit index.
// - Several matching filters report the lowest-numbered one.
// - Wide mode: two 32-bit filters, bytes 0-3 filter 0, 4-7 filter 1.
// - Half mode: four filters, 11 bits plus RTR or 14 extended bits.
// - Byte mode: eight filters on the first eight identifier bits.
// - Closed mode never fills foreground buffer or sets receive-full.
// - Four interrupt outputs from eleven flags, each with own enable.
// - Empty flag per unscheduled transmit buffer; transmit interrupt while enabled.
// - Receive-full and receive interrupt right after end of accepted frame.
// - Wake interrupt on bus activity only when sleep ack and enable set.
// - Warning flags when an error counter reaches 96.
// - Passive flags when an error counter exceeds 127.
// - Bus-off flag when transmit error counter exceeds 255.
// - Interrupt stays asserted while any enabled source flag is set.
// - Writing one clears a flag, zero no effect; persistent cause keeps it.
// - Error counters ignore all register writes.
// - Configuration registers writable only while soft reset is set.
// - Transmit pin forced recessive while the CPU is stopped.
// - Mode chosen from CPU state, stop-in-wait, sleep ack and soft reset.
// - Sleep and soft reset stop engine clock; power-down stops all.
// - Both buffers full plus new accepted message: discard and flag overrun.
// - Background copied to foreground only while receive-full is clear.
`timescale 1ns/10ps
`default_nettype none
`include "cif_map.vh"
module cif_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address / data / response
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Protocol engine side
  input  wire [31:0] rx_id_word,
  input  wire        rx_frame_valid,
  input  wire        rx_own_frame,
  input  wire [8:0]  rx_err_count,
  input  wire [8:0]  tx_err_count,
  input  wire [2:0]  tx_buf_sent,
  input  wire        bus_activity,
  input  wire        engine_tx,
  // CPU state
  input  wire        cpu_stop,
  input  wire        cpu_wait,
  // Pin, interrupts, mode and clock gates
  output reg         can_tx_pin,
  output reg         wake_irq,
  output reg         err_irq,
  output reg         rx_irq,
  output reg         tx_irq,
  output reg  [1:0]  can_mode,
  output reg         engine_clk_en,
  output reg         reg_clk_en,
  output reg         fg_load
);
  // Operating modes
  localparam [1:0] MODE_NORMAL = 2'h0;
  localparam [1:0] MODE_SLEEP  = 2'h1;
  localparam [1:0] MODE_SRST   = 2'h2;
  localparam [1:0] MODE_PDOWN  = 2'h3;

  reg  [7:0]  module_ctrl0_q, module_ctrl1_q, bit_timing0_q, bit_timing1_q;
  reg  [7:0]  rx_flag_q, rx_irq_en_q;
  reg  [2:0]  tx_empty_q, tx_irq_en_q;
  reg  [1:0]  accept_mode_q;
  reg  [2:0]  filter_hit_index_q;
  reg         bg_full_q;
  reg  [2:0]  bg_hit_q;
  reg         aw_hold_q, w_hold_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         rd_pend_q;
  reg  [7:0]  araddr_q;
  reg  [1:0]  mode_d;
  wire [127:0] acc_flat;
  wire [7:0]  acc_rd;

  // Lowest set bit of an eight-bit hit vector as a binary index
  function [3:0] lowest_hit;
    input [7:0] v;
    integer k;
    begin
      lowest_hit = 4'h0;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          lowest_hit = {1'b1, k[2:0]};
    end
  endfunction

  // Masked equality: bits with a don't-care one always match
  function masked_eq;
    input [31:0] id;
    input [31:0] pat;
    input [31:0] dc;
    begin
      masked_eq = ~|((id ^ pat) & ~dc);
    end
  endfunction

  wire soft_reset_req = module_ctrl0_q[`CIF_MC0_SOFT_RESET];
  wire sleep_ack      = module_ctrl0_q[`CIF_MC0_SLEEP_ACK];
  wire stop_in_wait   = module_ctrl0_q[`CIF_MC0_STOP_IN_WAIT];

  // Filter hit vector per mode; pattern byte k at k*8, its don't-care byte 64 bits higher
  integer    b;
  reg  [7:0] hits;
  always @* begin
    hits = 8'h00;
    case (accept_mode_q)
      `CIF_AM_WIDE: begin
        hits[0] = masked_eq(rx_id_word, acc_flat[31:0], acc_flat[95:64]);
        hits[1] = masked_eq(rx_id_word, acc_flat[63:32], acc_flat[127:96]);
      end
      `CIF_AM_HALF: begin
        // Upper 16 bits of the id word: 11 id + RTR, or 14 extended bits
        for (b = 0; b < 4; b = b + 1)
          hits[b] = ~|((rx_id_word[31:16] ^ acc_flat[b*16 +: 16]) & ~acc_flat[64 + b*16 +: 16]);
      end
      `CIF_AM_BYTE: begin
        // First eight identifier bits compared against every byte
        for (b = 0; b < 8; b = b + 1)
          hits[b] = ~|((rx_id_word[31:24] ^ acc_flat[b*8 +: 8]) & ~acc_flat[64 + b*8 +: 8]);
      end
      default: hits = 8'h00;
    endcase
  end

  wire [3:0] hit_enc   = lowest_hit(hits);
  wire       accepted  = rx_frame_valid & ~rx_own_frame & hit_enc[3] & (mode_d == MODE_NORMAL);
  wire       fg_free   = ~rx_flag_q[`CIF_RF_RX_FULL];
  wire       engine_on = (mode_d == MODE_NORMAL);

  // AXI write channel: address and data taken in either order
  wire       wr_fire   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire       acc_wr    = wr_fire & (awaddr_q[7:6] == 2'b01) & soft_reset_req & wstrb_q[0];
  wire [3:0] acc_wa    = {awaddr_q[5], awaddr_q[4:2]};
  wire [7:0] clr_rx    = (wr_fire && awaddr_q == `CIF_OFF_RX_FLAG_REG && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
  wire [2:0] clr_tx    = (wr_fire && awaddr_q == `CIF_OFF_TX_FLAG_REG && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;

  // Live causes of the rx_flag_reg flags; a cleared flag re-sets while its cause stays
  wire [7:0] cause;
  assign cause[`CIF_RF_RX_FULL]    = 1'b0;
  assign cause[`CIF_RF_OVERRUN]    = accepted & bg_full_q & ~fg_free;
  assign cause[`CIF_RF_BUSOFF]     = tx_err_count > `CIF_BUSOFF_LIMIT;
  assign cause[`CIF_RF_TX_PASSIVE] = tx_err_count > `CIF_PASSIVE_LIMIT;
  assign cause[`CIF_RF_RX_PASSIVE] = rx_err_count > `CIF_PASSIVE_LIMIT;
  assign cause[`CIF_RF_TX_WARN]    = tx_err_count >= `CIF_WARN_LIMIT;
  assign cause[`CIF_RF_RX_WARN]    = rx_err_count >= `CIF_WARN_LIMIT;
  assign cause[`CIF_RF_WAKE]       = bus_activity & sleep_ack & rx_irq_en_q[`CIF_RF_WAKE];

  // Mode from CPU state and control bits
  always @* begin
    if (cpu_stop || (cpu_wait && stop_in_wait))
      mode_d = MODE_PDOWN;
    else if (sleep_ack && !soft_reset_req)
      mode_d = MODE_SLEEP;
    else if (soft_reset_req)
      mode_d = MODE_SRST;
    else
      mode_d = MODE_NORMAL;
  end

  // Control registers; sleep ack is a host-visible bit kept here
  always @(posedge aclk) begin
    if (!aresetn) begin
      module_ctrl0_q <= `CIF_MC0_RESET;
      module_ctrl1_q <= 8'h00;
      bit_timing0_q  <= 8'h00;
      bit_timing1_q  <= 8'h00;
      accept_mode_q  <= `CIF_AM_WIDE;
      rx_irq_en_q    <= 8'h00;
      tx_irq_en_q    <= 3'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        `CIF_OFF_MODULE_CTRL0: module_ctrl0_q <= wdata_q[7:0];
        `CIF_OFF_MODULE_CTRL1: if (soft_reset_req) module_ctrl1_q <= wdata_q[7:0];
        `CIF_OFF_BIT_TIMING0:  if (soft_reset_req) bit_timing0_q <= wdata_q[7:0];
        `CIF_OFF_BIT_TIMING1:  if (soft_reset_req) bit_timing1_q <= wdata_q[7:0];
        `CIF_OFF_ACCEPT_CTRL:  if (soft_reset_req) accept_mode_q <= wdata_q[1:0];
        `CIF_OFF_RX_IRQ_EN:    rx_irq_en_q <= wdata_q[7:0];
        `CIF_OFF_TX_CTRL_REG:  tx_irq_en_q <= wdata_q[2:0];
        default: ;  // Error counters are read-only
      endcase
    end
  end

  // Receive path: background buffer, copy, hit index and flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_flag_q          <= 8'h00;
      bg_full_q          <= 1'b0;
      bg_hit_q           <= 3'h0;
      filter_hit_index_q <= 3'h0;
      fg_load            <= 1'b0;
      tx_empty_q         <= 3'h7;
    end else begin
      fg_load <= 1'b0;
      // Clear by ones first, then sets win over the clear
      rx_flag_q <= (rx_flag_q & ~clr_rx) | cause;
      if (soft_reset_req) begin
        bg_full_q <= 1'b0;  // Engine stopped; pending background frame dropped
      end else if (fg_free && engine_on && accepted) begin
        rx_flag_q[`CIF_RF_RX_FULL] <= 1'b1;
        filter_hit_index_q <= hit_enc[2:0];
        fg_load            <= 1'b1;
      end else if (accepted && !bg_full_q) begin
        bg_full_q <= 1'b1;
        bg_hit_q  <= hit_enc[2:0];
      end else if (fg_free && engine_on && bg_full_q) begin
        // Deferred copy when the host has released the foreground
        rx_flag_q[`CIF_RF_RX_FULL] <= 1'b1;
        filter_hit_index_q <= bg_hit_q;
        bg_full_q          <= 1'b0;
        fg_load            <= 1'b1;
      end
      // Host schedules by clearing; a sent buffer is empty again
      tx_empty_q <= (tx_empty_q & ~clr_tx) | tx_buf_sent;
    end
  end

  // Interrupt lines are registered ORs of enabled flags, so they track flags one cycle late
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_irq <= 1'b0;
      err_irq  <= 1'b0;
      rx_irq   <= 1'b0;
      tx_irq   <= 1'b0;
    end else begin
      wake_irq <= rx_flag_q[`CIF_RF_WAKE] & rx_irq_en_q[`CIF_RF_WAKE];
      err_irq  <= |(rx_flag_q[6:1] & rx_irq_en_q[6:1]);
      rx_irq   <= rx_flag_q[`CIF_RF_RX_FULL] & rx_irq_en_q[`CIF_RF_RX_FULL];
      tx_irq   <= |(tx_empty_q & tx_irq_en_q);
    end
  end

  // Pin protection, mode and clock gates
  always @(posedge aclk) begin
    if (!aresetn) begin
      can_tx_pin    <= 1'b1;
      can_mode      <= MODE_SRST;
      engine_clk_en <= 1'b0;
      reg_clk_en    <= 1'b1;
    end else begin
      // Recessive unless the engine is really running
      can_tx_pin    <= (cpu_stop || !engine_on) ? 1'b1 : engine_tx;
      can_mode      <= mode_d;
      engine_clk_en <= engine_on;
      reg_clk_en    <= (mode_d != MODE_PDOWN);
    end
  end

  // AXI write handshake: one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CIF_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q > 8'h7c || (awaddr_q > `CIF_OFF_MODE_STATUS && awaddr_q < `CIF_OFF_PATTERN_BASE))
                        ? `CIF_RESP_SLVERR : `CIF_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
    end
  end

  // AXI read: memory bytes come one cycle late, so data follow two edges on
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_q     <= 1'b0;
      araddr_q      <= 8'h00;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CIF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~rd_pend_q & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_q <= 1'b1;
        araddr_q  <= {s_axi_araddr[7:2], 2'b00};
      end
      if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CIF_RESP_OKAY;
        case (araddr_q)
          `CIF_OFF_MODULE_CTRL0: s_axi_rdata <= {24'h000000, module_ctrl0_q};
          `CIF_OFF_MODULE_CTRL1: s_axi_rdata <= {24'h000000, module_ctrl1_q};
          `CIF_OFF_BIT_TIMING0:  s_axi_rdata <= {24'h000000, bit_timing0_q};
          `CIF_OFF_BIT_TIMING1:  s_axi_rdata <= {24'h000000, bit_timing1_q};
          `CIF_OFF_RX_FLAG_REG:  s_axi_rdata <= {24'h000000, rx_flag_q};
          `CIF_OFF_RX_IRQ_EN:    s_axi_rdata <= {24'h000000, rx_irq_en_q};
          `CIF_OFF_TX_FLAG_REG:  s_axi_rdata <= {29'h00000000, tx_empty_q};
          `CIF_OFF_TX_CTRL_REG:  s_axi_rdata <= {29'h00000000, tx_irq_en_q};
          `CIF_OFF_ACCEPT_CTRL:  s_axi_rdata <= {24'h000000, 1'b0, filter_hit_index_q, 2'b00, accept_mode_q};
          `CIF_OFF_ERR_COUNTERS: s_axi_rdata <= {7'h00, tx_err_count, 7'h00, rx_err_count};
          `CIF_OFF_MODE_STATUS:  s_axi_rdata <= {30'h00000000, mode_d};
          default: begin
            if (araddr_q[7:6] != 2'b00 && araddr_q[7] == 1'b0) begin
              s_axi_rdata <= {24'h000000, acc_rd};
            end else begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= `CIF_RESP_SLVERR;
            end
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pattern bytes at 0x40..0x5c, don't-care bytes at 0x60..0x7c
  cif_accept_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (acc_wr),
    .wr_addr (acc_wa),
    .wr_data (wdata_q[7:0]),
    .rd_addr ({s_axi_araddr[5], s_axi_araddr[4:2]}),
    .rd_data (acc_rd),
    .flat    (acc_flat)
  );
endmodule
`default_nettype wire

// >>> testbench/cif_asserts.sv
// Port checks for cif_top: modes, clock gates, tx pin and copy strobe.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
module cif_asserts (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Watched ports
  input wire logic       cpu_stop,
  input wire logic       bus_activity,
  input wire logic       can_tx_pin,
  input wire logic       wake_irq,
  input wire logic [1:0] can_mode,
  input wire logic       engine_clk_en,
  input wire logic       reg_clk_en,
  input wire logic       fg_load
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Three cycles leave room for the one-register mode path
  sequence s_stopped;
    cpu_stop [*3];
  endsequence
  sequence s_wake_rise;
    $rose(wake_irq);
  endsequence
  a_stop_recessive: assert property (s_stopped |-> can_tx_pin)
    else $error("tx pin dominant in stop");
  a_stop_mode: assert property (s_stopped |-> can_mode == 2'h3)
    else $error("stop did not give power-down");
  a_pdown_gates: assert property ((can_mode == 2'h3) [*2] |-> !engine_clk_en && !reg_clk_en)
    else $error("clock running in power-down");
  a_low_gates: assert property ((can_mode == 2'h1 || can_mode == 2'h2) [*2] |-> !engine_clk_en && reg_clk_en)
    else $error("wrong gates in sleep or soft reset");
  a_normal_gates: assert property ((can_mode == 2'h0) [*2] |-> engine_clk_en && reg_clk_en)
    else $error("clock stopped in normal mode");
  a_wake_cause: assert property (s_wake_rise |-> $past(bus_activity, 2) && $past(can_mode, 2) == 2'h1)
    else $error("wake irq without activity in sleep");
  a_copy_single: assert property (fg_load |=> !fg_load)
    else $error("copy strobe repeated");
  a_copy_normal: assert property (fg_load |-> can_mode == 2'h0 || $past(can_mode) == 2'h0)
    else $error("copy outside normal mode");
endmodule
`default_nettype wire

// >>> testbench/cif_engine_model.sv
// Far-side model: protocol engine feeding frames, counters and bus events.
// Assumes its tasks are called from one process that follows aclk.
`timescale 1ns/10ps
`default_nettype none
module cif_engine_model (
  // Clock
  input  wire logic        aclk,
  // Engine outputs toward the filter
  output var  logic [31:0] rx_id_word,
  output var  logic        rx_frame_valid,
  output var  logic        rx_own_frame,
  output var  logic [8:0]  rx_err_count,
  output var  logic [8:0]  tx_err_count,
  output var  logic [2:0]  tx_buf_sent,
  output var  logic        bus_activity
);
  // Idle state; id lines carry a junk word outside frames
  initial begin
    rx_id_word = 32'h3c3c3c3c;
    {rx_frame_valid, rx_own_frame, rx_err_count, tx_err_count, tx_buf_sent, bus_activity} = 24'h000000;
  end
  // One end-of-frame strobe, id inverted once released
  task automatic frame(input logic [31:0] id);
    @(posedge aclk);
    rx_id_word <= id;
    rx_frame_valid <= 1'b1;
    @(posedge aclk);
    rx_id_word <= ~id;
    rx_frame_valid <= 1'b0;
  endtask
  // Counters move only between frames
  task automatic counts(input logic [8:0] r, input logic [8:0] t);
    @(posedge aclk);
    rx_err_count <= r;
    tx_err_count <= t;
  endtask
  // Buffer n reported sent for one cycle
  task automatic sent(input int n);
    @(posedge aclk);
    tx_buf_sent <= 3'(1 << n);
    @(posedge aclk);
    tx_buf_sent <= 3'h0;
  endtask
  // Bus traffic seen for n cycles
  task automatic activity(input int n);
    @(posedge aclk);
    bus_activity <= 1'b1;
    repeat (n) @(posedge aclk);
    bus_activity <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_can_id_filter_irq_modes.sv
// Bench for the CAN filter block: AXI4-Lite tasks and call sequences.
// Assumes cif_top, cif_asserts and cif_engine_model compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cif_map.vh"
module test_can_id_filter_irq_modes;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_stop, cpu_wait, engine_tx;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, q, q2;
  wire logic        awready, wready, bvalid, arready, rvalid, can_tx_pin, wake_irq, err_irq, rx_irq, tx_irq;
  wire logic        engine_clk_en, reg_clk_en, fg_load, frame_valid, own_frame, bus_act;
  wire logic [1:0]  bresp, rresp, can_mode;
  wire logic [31:0] rdata, id_word;
  wire logic [8:0]  rx_cnt, tx_cnt;
  wire logic [2:0]  buf_sent;
  int               err_total = 0, n_checks = 0, loads = 0, nl = 0, m, k;
  logic [7:0]       pm [4] = '{8'hfe, 8'hf0, 8'ha0, 8'hff};
  logic [7:0]       dm [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  logic [2:0]       hit [4] = '{3'h0, 3'h2, 3'h5, 3'h5};
  logic [8:0]       rc [6] = '{9'h05f, 9'h060, 9'h080, 9'h000, 9'h000, 9'h000};
  logic [8:0]       tc [6] = '{9'h05f, 9'h000, 9'h000, 9'h07f, 9'h080, 9'h100};
  logic [7:0]       fb [6] = '{8'h00, 8'h40, 8'h50, 8'h20, 8'h28, 8'h2c};

  cif_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_id_word(id_word),
    .rx_frame_valid(frame_valid), .rx_own_frame(own_frame), .rx_err_count(rx_cnt), .tx_err_count(tx_cnt),
    .tx_buf_sent(buf_sent), .bus_activity(bus_act), .engine_tx(engine_tx), .cpu_stop(cpu_stop),
    .cpu_wait(cpu_wait), .can_tx_pin(can_tx_pin), .wake_irq(wake_irq), .err_irq(err_irq), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .can_mode(can_mode), .engine_clk_en(engine_clk_en), .reg_clk_en(reg_clk_en),
    .fg_load(fg_load));
  cif_engine_model eng (.aclk(aclk), .rx_id_word(id_word), .rx_frame_valid(frame_valid),
    .rx_own_frame(own_frame), .rx_err_count(rx_cnt), .tx_err_count(tx_cnt), .tx_buf_sent(buf_sent),
    .bus_activity(bus_act));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Copy strobes counted as they happen
  always @(posedge aclk) begin
    if (fg_load) loads <= loads + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `CIF_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
                    input logic [1:0] er = `CIF_RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    q = rdata;
    check("rdata", q & msk, exp);
    check("rresp", 32'(rresp), 32'(er));
  endtask
  task automatic rx_frame;
    eng.frame(32'ha5a5a5a5);
    repeat (8) @(posedge aclk);
    check("loads", 32'(loads), 32'(nl));
  endtask
  task automatic cfg(input logic [31:0] mode);
    wr(`CIF_OFF_MODULE_CTRL0, 32'h1);
    wr(`CIF_OFF_ACCEPT_CTRL, mode);
  endtask

  // Watchdog far beyond the roughly one thousand cycles of the run
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test;
  end
  // Main sequence
  initial begin
    {aresetn, cpu_stop, cpu_wait, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, engine_tx} = 49'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check("mode", 32'(can_mode), 32'h2);
    check("gates", 32'({engine_clk_en, reg_clk_en}), 32'h1);
    rd(`CIF_OFF_MODULE_CTRL0, 32'hff, 32'h01);
    rd(`CIF_OFF_TX_FLAG_REG, 32'h7, 32'h7);
    wr(8'h30, 32'h0, `CIF_RESP_SLVERR);
    rd(8'h30, 32'hffffffff, 32'h0, `CIF_RESP_SLVERR);
    eng.counts(9'h005, 9'h009);
    rd(`CIF_OFF_ERR_COUNTERS, 32'h0, 32'h0);
    q2 = q;
    wr(`CIF_OFF_ERR_COUNTERS, 32'hffffffff);
    rd(`CIF_OFF_ERR_COUNTERS, 32'h0, 32'h0);
    check("counters", q, q2);
    for (m = 0; m < 4; m++) begin
      cfg(32'(m));
      for (k = 0; k < 8; k++) begin
        wr(`CIF_OFF_PATTERN_BASE + 8'(4 * k), pm[m][k] ? 32'ha5 : 32'h5a);
        wr(`CIF_OFF_DONTCARE_BASE + 8'(4 * k), dm[m][k] ? 32'hff : 32'h00);
      end
      wr(`CIF_OFF_MODULE_CTRL0, 32'h0);
      nl += (m != 3);
      rx_frame();
      rd(`CIF_OFF_ACCEPT_CTRL, 32'h73, 32'({hit[m], 2'h0, 2'(m)}));
      rd(`CIF_OFF_RX_FLAG_REG, 32'h1, 32'(m != 3));
      wr(`CIF_OFF_RX_FLAG_REG, 32'h1);
      rd(`CIF_OFF_RX_FLAG_REG, 32'h1, 32'h0);
    end
    wr(`CIF_OFF_ACCEPT_CTRL, 32'h0);
    rd(`CIF_OFF_ACCEPT_CTRL, 32'h3, 32'h3);
    rd(`CIF_OFF_PATTERN_BASE, 32'hff, 32'ha5);
    cfg(32'h2);
    wr(`CIF_OFF_MODULE_CTRL0, 32'h0);
    wr(`CIF_OFF_RX_IRQ_EN, 32'h03);
    nl++;
    rx_frame();
    check("rx_irq", 32'(rx_irq), 32'h1);
    rx_frame();
    rx_frame();
    rd(`CIF_OFF_RX_FLAG_REG, 32'h3, 32'h3);
    check("err_irq", 32'(err_irq), 32'h1);
    wr(`CIF_OFF_RX_FLAG_REG, 32'h2);
    nl++;
    wr(`CIF_OFF_RX_FLAG_REG, 32'h1);
    repeat (4) @(posedge aclk);
    check("loads", 32'(loads), 32'(nl));
    check("irqs", 32'({rx_irq, err_irq}), 32'h2);
    wr(`CIF_OFF_RX_IRQ_EN, 32'h7c);
    for (k = 0; k < 6; k++) begin
      eng.counts(rc[k], tc[k]);
      repeat (3) @(posedge aclk);
      rd(`CIF_OFF_RX_FLAG_REG, 32'h7c, 32'(fb[k]));
      check("err_irq", 32'(err_irq), 32'(fb[k] != 8'h00));
      wr(`CIF_OFF_RX_FLAG_REG, 32'h7c);
      rd(`CIF_OFF_RX_FLAG_REG, 32'h7c, 32'(fb[k]));
      eng.counts(9'h000, 9'h000);
      wr(`CIF_OFF_RX_FLAG_REG, 32'h7c);
      rd(`CIF_OFF_RX_FLAG_REG, 32'h7c, 32'h0);
    end
    wr(`CIF_OFF_TX_CTRL_REG, 32'h7);
    repeat (2) @(posedge aclk);
    check("tx_irq", 32'(tx_irq), 32'h1);
    wr(`CIF_OFF_TX_FLAG_REG, 32'h7);
    repeat (2) @(posedge aclk);
    check("tx_irq", 32'(tx_irq), 32'h0);
    eng.sent(1);
    rd(`CIF_OFF_TX_FLAG_REG, 32'h7, 32'h2);
    check("tx_irq", 32'(tx_irq), 32'h1);
    wr(`CIF_OFF_TX_CTRL_REG, 32'h5);
    repeat (2) @(posedge aclk);
    check("tx_irq", 32'(tx_irq), 32'h0);
    wr(`CIF_OFF_MODULE_CTRL0, 32'h4);
    cpu_wait <= 1'b1;
    repeat (4) @(posedge aclk);
    check("mode", 32'(can_mode), 32'h3);
    cpu_wait <= 1'b0;
    repeat (4) @(posedge aclk);
    check("mode", 32'(can_mode), 32'h0);
    wr(`CIF_OFF_MODULE_CTRL0, 32'h2);
    wr(`CIF_OFF_RX_IRQ_EN, 32'h80);
    check("mode", 32'(can_mode), 32'h1);
    eng.activity(4);
    repeat (4) @(posedge aclk);
    check("wake_irq", 32'(wake_irq), 32'h1);
    wr(`CIF_OFF_RX_IRQ_EN, 32'h00);
    wr(`CIF_OFF_RX_FLAG_REG, 32'h80);
    eng.activity(4);
    rd(`CIF_OFF_RX_FLAG_REG, 32'h80, 32'h0);
    wr(`CIF_OFF_MODULE_CTRL0, 32'h0);
    engine_tx <= 1'b0;
    repeat (4) @(posedge aclk);
    check("tx pin", 32'(can_tx_pin), 32'h0);
    cpu_stop <= 1'b1;
    repeat (4) @(posedge aclk);
    check("tx pin", 32'(can_tx_pin), 32'h1);
    cpu_stop <= 1'b0;
    stop_test;
  end
endmodule
bind cif_top cif_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .cpu_stop(cpu_stop), .bus_activity(bus_activity),
  .can_tx_pin(can_tx_pin), .wake_irq(wake_irq), .can_mode(can_mode), .engine_clk_en(engine_clk_en),
  .reg_clk_en(reg_clk_en), .fg_load(fg_load));
`default_nettype wire
